/* File: rmc_top.sv */
/*
 * Regulator mode controller: mode field under a write-lock key, automatic
 * normal/economy switching, settling timers, mode-done flag and interrupt,
 * all behind an AXI4-Lite slave.
 * Assumes: one 250 MHz clock; oscillator run levels arrive asynchronously;
 * sleep state and sleep-stop bits come from logic on the same clock.
 */
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
// Functional notes
// - key 0x0096 unlocks, any other relocks
// - mode code 0x2 selects normal operation
// - mode code 0x3 selects economy operation
// - mode code 0x0 selects automatic switching
// - mode code 0x5 selects charge pump supply
// - fast clocks stopped 1 ms, then economy
// - fast clock start returns to normal
// - sleep all stopped: economy at once, no flag
// - sleep crystal only: 1 ms, economy, flag
// - wake picks economy only if crystal alone
// - leaving charge pump sets flag after 10 ms (here only when economy or automatic mode follows)
// - pump sleeps only with crystal kept running (here pump_enable follows the mode field alone)
`timescale 1ns/1ps
module rmc_top
    import rmc_pkg::*;
#(
    parameter int AUTO_CYC = `RMC_T_AUTO_MS * `RMC_CLK_KHZ,
    parameter int SETTLE_CYC = `RMC_T_SETTLE_MS * `RMC_CLK_KHZ
) (
    input wire logic clk,
    input wire logic nrst,
    input wire rmc_pkg::rmc_axi_req_s axi_req,
    output rmc_pkg::rmc_axi_rsp_s axi_rsp,
    input wire logic low_speed_crystal_run,
    input wire logic [2:0] fast_clock_run,
    input wire logic sleep_state,
    input wire logic crystal_sleep_stop_bit,
    input wire logic [2:0] fast_sleep_stop,
    output logic economy_drive,
    output logic pump_enable,
    output logic [1:0] pump_clock_divider,
    output logic irq
);
    import rmc_pkg::*;

    localparam int CNT_MAX = 2 ** 22;
    // last count of each delay; the counters start from zero
    localparam rmc_cnt_t AUTO_LAST = rmc_cnt_t'(AUTO_CYC - 1);
    localparam rmc_cnt_t SETTLE_LAST = rmc_cnt_t'(SETTLE_CYC - 1);

    // refuse delays the counters cannot hold
    if (AUTO_CYC < 1 || AUTO_CYC > CNT_MAX || SETTLE_CYC < 1 || SETTLE_CYC > CNT_MAX) begin : g_chk
        $error("rmc_top: delay counts out of range");
    end

    rmc_state_s q;
    rmc_state_s n;
    logic wr_fire;
    logic mode_wr_ok;
    logic clr_hit;
    logic fast_any;
    logic sleep_rise;
    logic sleep_fall;
    logic all_stop;
    logic xtal_only;
    logic done_set;

    // word decode shared by write and read responses
    function automatic logic is_mapped(input logic [`RMC_ADDR_W-1:0] a);
        case (a)
            `RMC_OFS_LOCK, `RMC_OFS_CTRL, `RMC_OFS_TIM, `RMC_OFS_FLAG,
            `RMC_OFS_CLR, `RMC_OFS_ENA, `RMC_OFS_STAT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] rd_word(input logic [`RMC_ADDR_W-1:0] a, input rmc_state_s s);
        case (a)
            `RMC_OFS_LOCK: rd_word = {31'h0000_0000, s.unlock};
            `RMC_OFS_CTRL: rd_word = {29'h0000_0000, s.mode};
            `RMC_OFS_TIM: rd_word = {30'h0000_0000, s.div};
            `RMC_OFS_FLAG: rd_word = {31'h0000_0000, s.done};
            `RMC_OFS_ENA: rd_word = {31'h0000_0000, s.irq_en};
            `RMC_OFS_STAT: rd_word = {26'h000_0000, s.op, s.settling, s.pump, s.econ, s.unlock};
            default: rd_word = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic mode_legal(input logic [2:0] m);
        mode_legal = (m == `RMC_MODE_AUTO) || (m == `RMC_MODE_NORM) ||
                     (m == `RMC_MODE_ECON) || (m == `RMC_MODE_SECO);
    endfunction

    // bus handshakes and decoded write events
    assign wr_fire = q.aw_held && q.w_held && !q.bvalid;
    assign mode_wr_ok = wr_fire && q.awaddr == `RMC_OFS_CTRL && q.wstrb[0] && q.unlock &&
                        mode_legal(q.wdata[2:0]);
    assign clr_hit = wr_fire && q.awaddr == `RMC_OFS_CLR && q.wstrb[0] && q.wdata[`RMC_DONE_BIT];
    assign axi_rsp.awready = !q.aw_held && !q.bvalid;
    assign axi_rsp.wready = !q.w_held && !q.bvalid;
    assign axi_rsp.bvalid = q.bvalid;
    assign axi_rsp.bresp = q.bresp;
    assign axi_rsp.arready = !q.rvalid;
    assign axi_rsp.rvalid = q.rvalid;
    assign axi_rsp.rdata = q.rdata;
    assign axi_rsp.rresp = q.rresp;

    // clock and sleep conditions seen by the automatic switching
    assign fast_any = |q.fast_s;
    assign sleep_rise = sleep_state && !q.sleep_d;
    assign sleep_fall = !sleep_state && q.sleep_d;
    assign all_stop = crystal_sleep_stop_bit && (&fast_sleep_stop);
    assign xtal_only = !crystal_sleep_stop_bit && (&fast_sleep_stop);

    // outputs straight from the state record
    assign economy_drive = q.econ;
    assign pump_enable = q.pump;
    assign pump_clock_divider = q.div;
    assign irq = q.done && q.irq_en;

    // next state of the whole block
    always_comb begin
        n = q;
        done_set = 1'b0;
        // two flops per oscillator level; only the second one is read
        n.xtal_m = low_speed_crystal_run;
        n.xtal_s = q.xtal_m;
        n.fast_m = fast_clock_run;
        n.fast_s = q.fast_m;
        // last cycle's sleep level for the sleep and wake edge detectors
        n.sleep_d = sleep_state;

        // automatic switching between normal and economy
        if (q.mode == `RMC_MODE_AUTO) begin
            case (q.op)
                OP_NORM: begin
                    if (sleep_rise && all_stop) begin
                        n.op = OP_ECON;
                    end else if (sleep_rise && xtal_only) begin
                        n.op = OP_WAIT;
                        n.wcnt = '0;
                    end else if (!sleep_state && !fast_any && q.xtal_s) begin
                        n.op = OP_WAIT;
                        n.wcnt = '0;
                    end
                end
                OP_WAIT: begin
                    if (sleep_fall) begin
                        n.op = (!fast_any && q.xtal_s) ? OP_ECON : OP_NORM;
                    end else if (!sleep_state && fast_any) begin
                        n.op = OP_NORM;
                    end else if (q.wcnt == AUTO_LAST) begin
                        n.op = OP_ECON;
                        done_set = 1'b1;
                    end else begin
                        n.wcnt = q.wcnt + 22'h00_0001;
                    end
                end
                OP_ECON: begin
                    if (sleep_fall) begin
                        n.op = (!fast_any && q.xtal_s) ? OP_ECON : OP_NORM;
                    end else if (!sleep_state && fast_any) begin
                        n.op = OP_NORM;
                    end
                end
                default: n.op = OP_NORM;
            endcase
        end else begin
            n.op = OP_NORM;
        end

        // settling after the charge pump hands back to the regulator
        if (q.settling) begin
            if (q.scnt == SETTLE_LAST) begin
                n.settling = 1'b0;
                done_set = 1'b1;
            end else begin
                n.scnt = q.scnt + 22'h00_0001;
            end
        end

        // write address and data, taken in either order
        if (axi_req.awvalid && axi_rsp.awready) begin
            n.aw_held = 1'b1;
            n.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            n.w_held = 1'b1;
            n.wdata = axi_req.wdata;
            n.wstrb = axi_req.wstrb;
        end

        // register write effects and response
        if (wr_fire) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = is_mapped(q.awaddr) ? `RMC_RESP_OKAY : `RMC_RESP_SLVERR;
            if (q.awaddr == `RMC_OFS_LOCK && q.wstrb[1:0] == 2'b11) begin
                n.unlock = (q.wdata[15:0] == `RMC_UNLOCK_KEY);
            end
            if (q.awaddr == `RMC_OFS_TIM && q.wstrb[0] && q.unlock) begin
                n.div = q.wdata[1:0];
            end
            if (q.awaddr == `RMC_OFS_ENA && q.wstrb[0]) begin
                n.irq_en = q.wdata[0];
            end
        end
        if (mode_wr_ok) begin
            n.mode = q.wdata[2:0];
            n.op = OP_NORM;
            if (q.mode == `RMC_MODE_SECO && (q.wdata[2:0] == `RMC_MODE_AUTO ||
                                             q.wdata[2:0] == `RMC_MODE_ECON)) begin
                n.settling = 1'b1;
                n.scnt = '0;
            end
        end
        if (q.bvalid && axi_req.bready) begin
            n.bvalid = 1'b0;
        end

        // read channel: one word answered the cycle after the address
        if (q.rvalid && axi_req.rready) begin
            n.rvalid = 1'b0;
        end
        if (axi_req.arvalid && !q.rvalid) begin
            n.rvalid = 1'b1;
            n.rdata = rd_word(axi_req.araddr, q);
            n.rresp = is_mapped(axi_req.araddr) ? `RMC_RESP_OKAY : `RMC_RESP_SLVERR;
        end

        // sticky flag: a hardware set wins over a software clear
        n.done = done_set || (q.done && !clr_hit);

        // regulator drive derived from the mode that will stand
        n.econ = (n.mode == `RMC_MODE_ECON) || (n.mode == `RMC_MODE_SECO) ||
                 (n.mode == `RMC_MODE_AUTO && n.op == OP_ECON);
        n.pump = (n.mode == `RMC_MODE_SECO);
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            // the mode comes up normal and the divider at its reset code
            q.mode <= `RMC_MODE_RST;
            q.div <= `RMC_DIV_RST;
        end else begin
            q <= n;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // checks on the mode logic
    chk_key_unlock: assert property (
        wr_fire && q.awaddr == `RMC_OFS_LOCK && q.wstrb[1:0] == 2'b11
        |=> q.unlock == ($past(q.wdata[15:0]) == `RMC_UNLOCK_KEY))
        else $error("lock key not applied");
    chk_locked_mode: assert property (
        wr_fire && !q.unlock && q.awaddr == `RMC_OFS_CTRL |=> $stable(q.mode) ##1 $stable(q.mode))
        else $error("locked write changed the mode");
    chk_fixed_drive: assert property (
        q.mode == `RMC_MODE_NORM |-> !economy_drive && !pump_enable)
        else $error("normal mode not in normal drive");
    chk_pump_drive: assert property (
        q.mode == `RMC_MODE_SECO |-> economy_drive && pump_enable)
        else $error("pump mode without pump");
    chk_auto_wait: assert property (
        q.mode == `RMC_MODE_AUTO && q.op == OP_WAIT && q.wcnt == AUTO_LAST && !sleep_state &&
        !sleep_fall && !fast_any && !mode_wr_ok |=> economy_drive && q.done)
        else $error("auto wait did not end in economy");
    chk_fast_return: assert property (
        q.mode == `RMC_MODE_AUTO && q.op == OP_ECON && !sleep_state && !sleep_fall && fast_any
        |=> !economy_drive)
        else $error("fast clock start kept economy");
    chk_sleep_stop: assert property (
        q.mode == `RMC_MODE_AUTO && q.op == OP_NORM && sleep_rise && all_stop && !mode_wr_ok &&
        !q.settling && !clr_hit |=> economy_drive && q.done == $past(q.done))
        else $error("sleep entry not in economy");
    chk_settle_done: assert property (
        q.settling && q.scnt == SETTLE_LAST && !mode_wr_ok |=> q.done && !q.settling)
        else $error("settle did not set the flag");
    chk_flag_sticky: assert property (
        q.done && !clr_hit |=> q.done)
        else $error("mode-done flag lost");
    chk_econ_drive: assert property (
        q.mode == `RMC_MODE_ECON |-> economy_drive && !pump_enable)
        else $error("economy mode not in reduced drive");
    chk_mode_write: assert property (
        mode_wr_ok |=> q.mode == $past(q.wdata[2:0]))
        else $error("unlocked mode write not applied");
    chk_auto_normal: assert property (
        mode_wr_ok && q.wdata[2:0] == `RMC_MODE_AUTO |=> q.op == OP_NORM && !economy_drive)
        else $error("automatic mode did not start normal");

    // automatic mode: start of the wait, the sleep paths and the wake-up choice
    chk_auto_start: assert property (
        q.mode == `RMC_MODE_AUTO && q.op == OP_NORM && !sleep_state && !fast_any &&
        q.xtal_s && !mode_wr_ok |=> q.op == OP_WAIT && q.wcnt == '0)
        else $error("stopped fast clocks did not start the wait");
    chk_sleep_wait: assert property (
        q.mode == `RMC_MODE_AUTO && q.op == OP_NORM && sleep_rise && xtal_only && !mode_wr_ok
        |=> q.op == OP_WAIT && !economy_drive)
        else $error("crystal-only sleep did not start the wait");
    chk_sleep_done: assert property (
        q.mode == `RMC_MODE_AUTO && q.op == OP_WAIT && q.wcnt == AUTO_LAST && sleep_state &&
        !mode_wr_ok |=> economy_drive && q.done)
        else $error("sleep wait did not end in economy");
    chk_wake_pick: assert property (
        q.mode == `RMC_MODE_AUTO && q.op != OP_NORM && sleep_fall && !mode_wr_ok
        |=> economy_drive == $past(!fast_any && q.xtal_s))
        else $error("wake-up chose the wrong drive");

    // settling count, divider lock and the sticky flag
    chk_settle_start: assert property (
        mode_wr_ok && q.mode == `RMC_MODE_SECO && (q.wdata[2:0] == `RMC_MODE_AUTO ||
        q.wdata[2:0] == `RMC_MODE_ECON) |=> q.settling && q.scnt == '0 && !pump_enable)
        else $error("leaving the pump did not start settling");
    chk_settle_count: assert property (
        q.settling && q.scnt != SETTLE_LAST && !mode_wr_ok
        |=> q.settling && q.scnt == $past(q.scnt) + 22'h00_0001)
        else $error("settling count did not advance");
    chk_div_locked: assert property (
        wr_fire && !q.unlock && q.awaddr == `RMC_OFS_TIM |=> $stable(pump_clock_divider))
        else $error("locked write changed the divider");
    chk_flag_clear: assert property (
        clr_hit && !done_set |=> !q.done && !irq)
        else $error("mode-done flag not cleared");
    chk_set_wins: assert property (
        done_set |=> q.done)
        else $error("mode-done flag set was lost");

    // bus answers one cycle after the request is complete
    chk_write_answer: assert property (
        wr_fire |=> axi_rsp.bvalid)
        else $error("write not answered");
    chk_read_answer: assert property (
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read not answered");
    chk_bad_address: assert property (
        wr_fire && !is_mapped(q.awaddr) |=> axi_rsp.bresp == `RMC_RESP_SLVERR)
        else $error("unmapped write not refused");

    // main scenarios
    cov_auto_econ: cover property (q.op == OP_WAIT ##1 q.op == OP_ECON);
    cov_settle: cover property ($fell(q.settling) ##1 q.done);
    cov_irq: cover property ($rose(irq));
    cov_sleep_wait: cover property (sleep_state && q.op == OP_WAIT ##1 q.op == OP_ECON);
    cov_wake_econ: cover property (sleep_fall ##1 q.op == OP_ECON);
endmodule

/* File: rmc_map.svh */
/*
 * Register map, field codes, reset values and timing figures of the
 * regulator mode controller.
 * Assumes: included by the package and by the bench, 250 MHz clock.
 */
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH

// register byte offsets on the AXI4-Lite slave
`define RMC_ADDR_W 8
`define RMC_OFS_LOCK 8'h00
`define RMC_OFS_CTRL 8'h04
`define RMC_OFS_TIM 8'h08
`define RMC_OFS_FLAG 8'h0C
`define RMC_OFS_CLR 8'h10
`define RMC_OFS_ENA 8'h14
`define RMC_OFS_STAT 8'h18

// write lock key
`define RMC_UNLOCK_KEY 16'h0096

// regulator mode field codes
`define RMC_MODE_AUTO 3'h0
`define RMC_MODE_NORM 3'h2
`define RMC_MODE_ECON 3'h3
`define RMC_MODE_SECO 3'h5

// reset values
`define RMC_MODE_RST 3'h2
`define RMC_DIV_RST 2'h0

// bit positions
`define RMC_DONE_BIT 0

// timing figures and clock rate
`define RMC_T_AUTO_MS 1
`define RMC_T_SETTLE_MS 10
`define RMC_CLK_KHZ 250000

// bus responses
`define RMC_RESP_OKAY 2'h0
`define RMC_RESP_SLVERR 2'h2

`endif

/* File: rmc_pkg.sv */
/*
 * Types of the regulator mode controller: bus carriers, operation
 * states and the packed state record of the top module.
 * Assumes: rmc_map.svh is on the include path.
 */
package rmc_pkg;
    `include "rmc_map.svh"

    typedef logic [21:0] rmc_cnt_t;

    // automatic-mode operation
    typedef enum logic [1:0] {OP_NORM, OP_WAIT, OP_ECON} rmc_op_e;

    typedef struct packed {
        logic awvalid;
        logic [`RMC_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`RMC_ADDR_W-1:0] araddr;
        logic rready;
    } rmc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rmc_axi_rsp_s;

    typedef struct packed {
        logic xtal_m;
        logic xtal_s;
        logic [2:0] fast_m;
        logic [2:0] fast_s;
        logic sleep_d;
        logic unlock;
        logic [2:0] mode;
        logic [1:0] div;
        rmc_op_e op;
        rmc_cnt_t wcnt;
        logic settling;
        rmc_cnt_t scnt;
        logic done;
        logic irq_en;
        logic econ;
        logic pump;
        logic aw_held;
        logic [`RMC_ADDR_W-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rmc_state_s;
endpackage

/* File: tb_top.sv */
/*
 * Self-checking bench of the regulator mode controller: bus access, lock key,
 * mode codes, automatic switching, sleep handling, settling delay, interrupt.
 * Assumes: rmc_pkg and rmc_top compiled first, shortened timing counts.
 */
`timescale 1ns/1ps
`include "rmc_map.svh"
module tb_top;
    import rmc_pkg::*;
    localparam int AUTO = 20;
    localparam int SETTLE = 50;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    // response ready levels stay high: every answer is taken in the cycle it stands
    rmc_axi_req_s req = '{bready: 1'b1, rready: 1'b1, default: '0};
    rmc_axi_rsp_s rsp;
    logic xtal = 1'b1;
    logic [2:0] fast = 3'h1;
    logic sleep = 1'b0;
    logic xtal_stop = 1'b0;
    logic [2:0] fast_stop = 3'h0;
    logic econ, pump, irq;
    logic [1:0] div;
    logic [31:0] rd;
    logic [1:0] rr;
    int bad_count = 0;
    int cmp_count = 0;

    rmc_top #(.AUTO_CYC(AUTO), .SETTLE_CYC(SETTLE)) u_rmc_top (.clk(clk), .nrst(nrst),
        .axi_req(req), .axi_rsp(rsp), .low_speed_crystal_run(xtal), .fast_clock_run(fast),
        .sleep_state(sleep), .crystal_sleep_stop_bit(xtal_stop), .fast_sleep_stop(fast_stop),
        .economy_drive(econ), .pump_enable(pump), .pump_clock_divider(div), .irq(irq));

    // 250 MHz clock
    always #2 clk = ~clk;

    // verdict and end of run
    task automatic wrap_up();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // compare and count
    task automatic eq(input logic [31:0] got, input logic [31:0] want, input string m);
        cmp_count++;
        if (got !== want) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    // write with address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw_go, w_go, hs_aw, hs_w;
        aw_go = 1'b1;
        w_go = 1'b1;
        n = 0;
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.wvalid <= 1'b1;
        while ((aw_go || w_go) && n < 50) begin
            #1;
            hs_aw = aw_go && rsp.awready;
            hs_w = w_go && rsp.wready;
            @(posedge clk);
            n++;
            if (hs_aw) begin
                aw_go = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (hs_w) begin
                w_go = 1'b0;
                req.wvalid <= 1'b0;
            end
        end
        hs_aw = 1'b0;
        while (!hs_aw && n < 50) begin
            #1;
            hs_aw = rsp.bvalid;
            rr = rsp.bresp;
            @(posedge clk);
            n++;
        end
        if (!hs_aw) begin
            eq(0, 1, "write timeout");
            wrap_up();
        end
    endtask

    // read one register into rd and rr
    task automatic rdr(input logic [7:0] a);
        int n;
        logic hs;
        n = 0;
        hs = 1'b0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        while (!hs && n < 50) begin
            #1;
            hs = rsp.arready;
            @(posedge clk);
            n++;
        end
        req.arvalid <= 1'b0;
        hs = 1'b0;
        while (!hs && n < 50) begin
            #1;
            hs = rsp.rvalid;
            rd = rsp.rdata;
            rr = rsp.rresp;
            @(posedge clk);
            n++;
        end
        if (!hs) begin
            eq(0, 1, "read timeout");
            wrap_up();
        end
    endtask

    // wait for economy_drive or irq to reach a level within lo..hi edges
    task automatic span(input bit sel, input logic want, input int lo, input int hi,
        input string m);
        int n;
        logic v;
        n = 0;
        #1;
        v = sel ? irq : econ;
        while (v !== want && n < hi) begin
            @(posedge clk);
            n++;
            #1;
            v = sel ? irq : econ;
        end
        eq({31'h0, v === want && n >= lo}, 32'h1, m);
        if (v !== want) begin
            wrap_up();
        end
        @(posedge clk);
    endtask

    // a level that must hold for k edges
    task automatic stay(input bit sel, input logic want, input int k, input string m);
        logic ok;
        ok = 1'b1;
        repeat (k) begin
            @(posedge clk);
            #1;
            ok = ok && ((sel ? irq : econ) === want);
        end
        eq({31'h0, ok}, 32'h1, m);
        @(posedge clk);
    endtask

    task automatic sc_reset();
        rdr(`RMC_OFS_CTRL);
        eq(rd, 32'h0000_0002, "reset mode");
        rdr(`RMC_OFS_STAT);
        eq(rd, 32'h0000_0000, "reset status");
        rdr(8'h1c);
        eq({30'h0, rr}, 32'h0000_0002, "unmapped resp");
        eq(rd, 32'h0000_0000, "unmapped data");
        wr(8'h1c, 32'h0000_0001);
        eq({30'h0, rr}, 32'h0000_0002, "unmapped write resp");
        eq(irq, 0, "reset irq");
    endtask

    task automatic sc_lock();
        fast <= 3'h0;
        wr(`RMC_OFS_CTRL, 32'h0000_0003);
        eq({30'h0, rr}, 32'h0000_0000, "locked write okay");
        rdr(`RMC_OFS_CTRL);
        eq(rd, 32'h0000_0002, "locked write kept");
        wr(`RMC_OFS_LOCK, 32'h0000_0096);
        rdr(`RMC_OFS_LOCK);
        eq(rd, 32'h0000_0001, "unlocked");
        wr(`RMC_OFS_CTRL, 32'h0000_0001);
        rdr(`RMC_OFS_CTRL);
        eq(rd, 32'h0000_0002, "illegal code kept");
        wr(`RMC_OFS_CTRL, 32'h0000_0003);
        eq(econ, 1, "economy code");
        wr(`RMC_OFS_CTRL, 32'h0000_0002);
        eq(econ, 0, "normal code");
        wr(`RMC_OFS_LOCK, 32'h0000_1234);
        rdr(`RMC_OFS_LOCK);
        eq(rd, 32'h0000_0000, "relocked");
        wr(`RMC_OFS_TIM, 32'h0000_0001);
        eq(div, 0, "locked divider kept");
    endtask

    task automatic sc_pump();
        wr(`RMC_OFS_LOCK, 32'h0000_0096);
        wr(`RMC_OFS_TIM, 32'h0000_0002);
        eq(div, 2, "divider");
        wr(`RMC_OFS_CTRL, 32'h0000_0005);
        eq(pump, 1, "pump on");
        rdr(`RMC_OFS_STAT);
        eq(rd, 32'h0000_0007, "pump status");
        wr(`RMC_OFS_ENA, 32'h0000_0001);
        wr(`RMC_OFS_CTRL, 32'h0000_0003);
        eq(pump, 0, "pump off");
        rdr(`RMC_OFS_STAT);
        eq(rd, 32'h0000_000B, "settling status");
        span(1, 1, SETTLE - 4, SETTLE + 4, "settle flag");
        wr(`RMC_OFS_ENA, 32'h0000_0000);
        eq(irq, 0, "irq masked");
        rdr(`RMC_OFS_FLAG);
        eq(rd, 32'h0000_0001, "flag sticky");
        wr(`RMC_OFS_ENA, 32'h0000_0001);
        eq(irq, 1, "irq unmasked");
        wr(`RMC_OFS_CLR, 32'h0000_0001);
        eq(irq, 0, "irq cleared");
    endtask

    task automatic sc_auto();
        wr(`RMC_OFS_CTRL, 32'h0000_0000);
        eq(econ, 0, "auto starts normal");
        span(0, 1, AUTO - 4, AUTO + 8, "auto economy delay");
        eq(irq, 1, "auto flag");
        rdr(`RMC_OFS_STAT);
        eq(rd, 32'h0000_0023, "auto economy status");
        wr(`RMC_OFS_CLR, 32'h0000_0001);
        fast <= 3'h2;
        span(0, 0, 0, 4, "fast start normal");
    endtask

    task automatic sc_sleep();
        xtal_stop <= 1'b1;
        fast_stop <= 3'h7;
        @(posedge clk);
        sleep <= 1'b1;
        fast <= 3'h0;
        xtal <= 1'b0;
        span(0, 1, 0, 2, "sleep all stopped");
        stay(1, 0, 2 * AUTO, "no flag on sleep");
        xtal <= 1'b1;
        repeat (4) @(posedge clk);
        sleep <= 1'b0;
        stay(0, 1, 4, "wake crystal only");
        fast <= 3'h4;
        span(0, 0, 0, 4, "external clock start");
        xtal_stop <= 1'b0;
        fast_stop <= 3'h7;
        @(posedge clk);
        sleep <= 1'b1;
        fast <= 3'h0;
        span(0, 1, AUTO - 2, AUTO + 6, "sleep crystal kept");
        eq(irq, 1, "sleep flag");
        fast <= 3'h1;
        repeat (3) @(posedge clk);
        sleep <= 1'b0;
        span(0, 0, 0, 3, "wake fast running");
    endtask

    // reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        sc_reset();
        sc_lock();
        sc_pump();
        sc_auto();
        sc_sleep();
        wrap_up();
    end
endmodule
